// ===== src/sac_pkg.sv
// Constants shared by the switch array serial control block
package sac_pkg;
  localparam int unsigned CHANNELS = 32;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WAKEUP_NS = 1000;
  localparam int unsigned WAKEUP_CYCLES = (WAKEUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SERIAL_MAX_HZ = 66_000_000;
  localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;
  localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
  localparam logic [31:0] EVEN_MASK = 32'h5555_5555;
  localparam logic [31:0] ODD_MASK = 32'hAAAA_AAAA;
  typedef enum logic [1:0] {
    SAC_STANDBY,
    SAC_WAKING,
    SAC_ACTIVE
  } sac_state_t;
endpackage

// ===== src/sac_switch_array_serial_control.sv
// Serial shift register, latches, bank mode and standby for a 32 channel switch array
`timescale 1ns/100ps
`default_nettype none
module sac_switch_array_serial_control #(
  parameter int unsigned WAKEUP_COUNT = sac_pkg::WAKEUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standby_n,
  input wire logic modeIndividual,
  input wire logic serial_in_or_bank_select,
  input wire logic load_strobe_or_bank_enable,
  input wire logic latch_clear,
  input wire logic serialClk,
  output logic [31:0] switchOn,
  output logic serialOut,
  output logic serialOutEn,
  output logic awake
);
  // Wake counter is 16 bits wide and the switch bus must match the channel count
  if (WAKEUP_COUNT < 1 || WAKEUP_COUNT > 65535 || $bits(switchOn) != sac_pkg::CHANNELS) begin : g_bad_params
    $error("WAKEUP_COUNT out of range or switch width wrong");
  end

  // Two-stage synchronisers; the first stage is read only by the second
  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [5:0] next_syncA;
  logic [5:0] next_syncB;
  logic sStby;
  logic sMode;
  logic sData;
  logic sLoad;
  logic sClr;
  logic sSclk;
  assign {sStby, sMode, sData, sLoad, sClr, sSclk} = syncB;

  always_comb begin
    next_syncA = {standby_n, modeIndividual, serial_in_or_bank_select,
                  load_strobe_or_bank_enable, latch_clear, serialClk};
    next_syncB = syncA;
    if (!rst_n) begin
      next_syncA = 6'h00;
      next_syncB = 6'h00;
    end
  end

  always_ff @(posedge clk) begin
    syncA <= next_syncA;
    syncB <= next_syncB;
  end

  // Standby and wake-up sequencing
  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;
  logic [15:0] wakeCnt;
  logic [15:0] next_wakeCnt;

  always_comb begin
    next_state = state;
    next_wakeCnt = wakeCnt;
    case (state)
      sac_pkg::SAC_STANDBY: begin
        if (sStby) begin
          next_state = sac_pkg::SAC_WAKING;
          next_wakeCnt = 16'h0001;
        end
      end
      sac_pkg::SAC_WAKING: begin
        if (!sStby) begin
          next_state = sac_pkg::SAC_STANDBY;
        end else if (wakeCnt >= WAKEUP_COUNT[15:0]) begin
          next_state = sac_pkg::SAC_ACTIVE;
        end else begin
          next_wakeCnt = wakeCnt + 16'h0001;
        end
      end
      sac_pkg::SAC_ACTIVE: begin
        if (!sStby) begin
          next_state = sac_pkg::SAC_STANDBY;
        end
      end
      default: next_state = sac_pkg::SAC_STANDBY;
    endcase
    if (!rst_n) begin
      next_state = sac_pkg::SAC_STANDBY;
      next_wakeCnt = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
    wakeCnt <= next_wakeCnt;
  end

  wire logic run = (state == sac_pkg::SAC_ACTIVE);

  // Shift register, latches and outputs
  // Serial clock is oversampled, so 66 MHz needs a faster core clock than the default
  logic [31:0] shiftReg;
  logic [31:0] latchReg;
  logic prevSclk;
  logic prevMode;
  logic prevLoad;
  logic [31:0] next_shiftReg;
  logic [31:0] next_latchReg;
  logic [31:0] next_switchOn;
  logic next_serialOut;
  logic next_serialOutEn;
  logic next_prevSclk;
  logic next_prevMode;
  logic next_prevLoad;
  logic next_awake;

  always_comb begin
    next_shiftReg = shiftReg;
    next_latchReg = latchReg;
    next_switchOn = 32'h0000_0000;
    next_serialOut = 1'b0;
    next_serialOutEn = 1'b0;
    next_prevSclk = sSclk;
    next_prevMode = sMode && run;
    next_prevLoad = sLoad;
    next_awake = (next_state == sac_pkg::SAC_ACTIVE);
    if (run && sMode) begin
      if (!prevMode) begin
        next_shiftReg = sac_pkg::SHIFT_RESET;
      end else if (sSclk && !prevSclk) begin
        next_shiftReg = {shiftReg[30:0], sData};
      end
      if (sClr) begin
        next_latchReg = sac_pkg::LATCH_RESET;
      end else if (!sLoad) begin
        next_latchReg = next_shiftReg;
      end
      next_switchOn = next_latchReg;
      next_serialOut = next_shiftReg[31];
      next_serialOutEn = 1'b1;
    end else if (run) begin
      if (sLoad) begin
        next_switchOn = sData ? sac_pkg::EVEN_MASK : sac_pkg::ODD_MASK;
      end
    end
    // Standby and bank mode leave the serial output undriven
    if (!rst_n) begin
      next_shiftReg = sac_pkg::SHIFT_RESET;
      next_latchReg = sac_pkg::LATCH_RESET;
      next_switchOn = 32'h0000_0000;
      next_serialOut = 1'b0;
      next_serialOutEn = 1'b0;
      next_prevSclk = 1'b0;
      next_prevMode = 1'b0;
      next_prevLoad = 1'b0;
      next_awake = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    shiftReg <= next_shiftReg;
    latchReg <= next_latchReg;
    switchOn <= next_switchOn;
    serialOut <= next_serialOut;
    serialOutEn <= next_serialOutEn;
    prevSclk <= next_prevSclk;
    prevMode <= next_prevMode;
    prevLoad <= next_prevLoad;
    awake <= next_awake;
  end

  // Checks
  a_standby_all_off: assert property (@(posedge clk) disable iff (!rst_n)
    !sStby |=> ##1 (switchOn == 32'h0000_0000)) else $error("switch on in standby");
  a_wake_delay: assert property (@(posedge clk) disable iff (!rst_n)
    (state == sac_pkg::SAC_STANDBY) |=> !awake) else $error("awake too early");
  a_clear_forces: assert property (@(posedge clk) disable iff (!rst_n)
    (run && sMode && prevMode && sClr) |=> (switchOn == 32'h0000_0000)) else $error("clear ignored");
  a_clear_keeps_shift: assert property (@(posedge clk) disable iff (!rst_n)
    (run && sMode && prevMode && sClr && !(sSclk && !prevSclk)) |=> $stable(shiftReg))
    else $error("clear touched shift");
  a_shift_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (run && sMode && prevMode && sSclk && !prevSclk) |=> (shiftReg[0] == $past(sData)))
    else $error("bit not captured");
  a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (run && sMode && prevMode && sLoad && !sClr) |=> $stable(latchReg)) else $error("latch moved");
  a_mode_rise_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (run && sMode && !prevMode) |=> (shiftReg == 32'h0000_0000)) else $error("shift not zeroed");
  a_bank_even: assert property (@(posedge clk) disable iff (!rst_n)
    (run && !sMode && sLoad && sData) |=> (switchOn == sac_pkg::EVEN_MASK)) else $error("even bank wrong");
  a_bank_disable: assert property (@(posedge clk) disable iff (!rst_n)
    (run && !sMode && !sLoad) |=> (switchOn == 32'h0000_0000 && !serialOutEn)) else $error("bank enable");
  a_serial_out: assert property (@(posedge clk) disable iff (!rst_n)
    serialOutEn |-> (serialOut == shiftReg[31])) else $error("serial out mismatch");
  a_bank_odd: assert property (@(posedge clk) disable iff (!rst_n)
    (run && !sMode && sLoad && !sData) |=> (switchOn == sac_pkg::ODD_MASK)) else $error("odd bank wrong");
  a_bank_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    (run && !sMode) |=> !serialOutEn) else $error("serial out driven in bank mode");
  a_latch_transparent: assert property (@(posedge clk) disable iff (!rst_n)
    (run && sMode && prevMode && !sLoad && !sClr) |=> (switchOn == shiftReg)) else $error("latch not transparent");
  a_wake_count: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(awake) |-> (wakeCnt >= WAKEUP_COUNT[15:0])) else $error("woke before interval");
  c_wake: cover property (@(posedge clk) disable iff (!rst_n) $rose(awake));
  c_clear: cover property (@(posedge clk) disable iff (!rst_n) run && sMode && sClr);
  c_mode_rise: cover property (@(posedge clk) disable iff (!rst_n) run && sMode && !prevMode);
  c_load: cover property (@(posedge clk) disable iff (!rst_n) run && sMode && !sLoad && prevLoad);
  c_bank_odd: cover property (@(posedge clk) disable iff (!rst_n) run && !sMode && sLoad && !sData);
endmodule
`default_nettype wire

// ===== sim/sac_host_model.sv
// Host controller model driving the serial and bank control pins
`timescale 1ns/100ps
`default_nettype none
module sac_host_model (
  input wire logic clk,
  input wire logic readback,
  output var logic sdata,
  output var logic sclk,
  output var logic strobeN
);
  initial begin
    sdata = 1'h0;
    sclk = 1'h0;
    strobeN = 1'h1;
  end
  // Half periods of 4 clk keep the oversampled clock legal
  // Readback is taken before each rise, so it returns the previous frame
  task automatic send(input logic [31:0] frame, output logic [31:0] back);
    for (int i = 31; i >= 0; i--) begin
      sdata = frame[i];
      repeat (4) @(negedge clk);
      back[i] = readback;
      sclk = 1'h1;
      repeat (4) @(negedge clk);
      sclk = 1'h0;
    end
    sdata = ~sdata; // Released data must not look valid
  endtask
  task automatic strobe();
    strobeN = 1'h0;
    repeat (4) @(negedge clk);
    strobeN = 1'h1;
  endtask
  task automatic bank(input logic sel, input logic en);
    sdata = sel;
    strobeN = en;
  endtask
endmodule
`default_nettype wire

// ===== sim/switch_array_serial_control_bench.sv
// Self-checking bench for the switch array serial control block
`timescale 1ns/100ps
`default_nettype none
module switch_array_serial_control_bench;
  logic clk = 1'h0, rst_n = 1'h0, standbyN = 1'h0, mode = 1'h1, clear = 1'h0, chk = 1'h0;
  wire logic sdata, sclk, strobeN;
  logic [31:0] switchOn, f, sr, rb;
  logic serialOut, serialOutEn, awake;
  logic [34:0] notes[$];
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  sac_host_model i_sac_host_model (.clk(clk), .readback(serialOut), .sdata(sdata), .sclk(sclk), .strobeN(strobeN));
  sac_switch_array_serial_control #(.WAKEUP_COUNT(1)) i_sac_switch_array_serial_control (
    .clk(clk), .rst_n(rst_n), .standby_n(standbyN), .modeIndividual(mode), .serial_in_or_bank_select(sdata),
    .load_strobe_or_bank_enable(strobeN), .latch_clear(clear), .serialClk(sclk), .switchOn(switchOn),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .awake(awake));
  task automatic check(input string name, input logic [34:0] seen, input logic [34:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Settle past the 3 clk input latency, then note {switchOn, serialOutEn, serialOut, awake}
  task automatic note(input logic [31:0] sw, input logic en, input logic so, input logic aw);
    repeat (8) @(negedge clk);
    notes.push_back({sw, en, so, aw});
    chk = 1'h1;
    @(negedge clk);
    chk = 1'h0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (chk) begin
      check("outputs", {switchOn, serialOutEn, serialOut, awake}, notes.pop_front());
    end
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    void'($urandom(38));
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    note(32'h0000_0000, 1'h0, 1'h0, 1'h0);
    standbyN = 1'h1;
    note(32'h0000_0000, 1'h1, 1'h0, 1'h1);
    f = $urandom;
    i_sac_host_model.send(f, rb);
    check("readback", {3'h0, rb}, 35'h0);
    i_sac_host_model.strobe();
    note(f, 1'h1, f[31], 1'h1);
    sr = $urandom;
    i_sac_host_model.send(sr, rb);
    check("readback", {3'h0, rb}, {3'h0, f});
    note(f, 1'h1, sr[31], 1'h1);
    clear = 1'h1;
    i_sac_host_model.strobe();
    note(32'h0000_0000, 1'h1, sr[31], 1'h1);
    clear = 1'h0;
    i_sac_host_model.strobe();
    note(sr, 1'h1, sr[31], 1'h1);
    $display("individual mode test done");
    mode = 1'h0;
    for (int k = 0; k < 4; k++) begin
      i_sac_host_model.bank(k[1], k[0]);
      note(k[0] ? (k[1] ? sac_pkg::EVEN_MASK : sac_pkg::ODD_MASK) : 32'h0000_0000, 1'h0, 1'h0, 1'h1);
    end
    $display("bank mode test done");
    mode = 1'h1;
    i_sac_host_model.strobe();
    note(32'h0000_0000, 1'h1, 1'h0, 1'h1);
    standbyN = 1'h0;
    note(32'h0000_0000, 1'h0, 1'h0, 1'h0);
    $display("mode change and standby test done");
    summarize();
  end
endmodule
`default_nettype wire
